// file: include/addr_pkg.sv
// constants, types and rule summary for the cpu addressing and stack logic
// assumes one clock domain; ram and rom sit inside or beside the block
// What this block does
// R1: table output drives both port nibbles
// R2: table sits in last 32 rom bytes
// R3: carry is table index msb
// R4: rom is 1024 or 2048 bytes
// R5: small variant folds rom top bit away
// R6: page and word pointers address ram
// R7: word pointer post modify, page untouched
// R8: word pointer selects one port bit
// R9: large ram is 8 pages of 16
// R10: direct mode uses full operand byte
// R11: zero page uses operand low nibble
// R12: call pushes pc, interrupt pc plus flags
// R13: 15 four nibble locations from 40h
// R14: location 3 sits at 4ch to 4fh
// R15: pointer decrements after push, increments before pop
// R16: stack pointer nibble at 7fh or 3fh
// R17: software initialises stack pointer before use
// R18: stack pointer never holds 15
// R19: locations 13, 14 shared with timer counts
// R20: table counter mapped into ram nibbles
// R21: table counter low nibble at 07ch
// R22: timer counts live in ram nibbles
// R23: nibbles 77h and 7bh stay free
// R24: small zero page overlaps low stack locations
// R25: small variant ignores counter top bit
// R26: fixed nibble order inside stack location
package addr_pkg;
    localparam int         RAM_DEPTH   = 128;
    localparam logic [7:0] STACK_BASE  = 8'h40;
    localparam logic [7:0] TC1_ADDR    = 8'h74;
    localparam logic [7:0] TC2_ADDR    = 8'h78;
    localparam logic [7:0] DC_ADDR     = 8'h7c;
    localparam logic [7:0] SPW_ADDR    = 8'h7f;
    localparam logic [3:0] SPW_BAD     = 4'hf;
    localparam logic [3:0] LOC_TC1     = 4'hd;
    localparam logic [3:0] LOC_TC2     = 4'he;
    localparam logic [10:0] TBL_BASE_L = 11'h7e0;
    localparam logic [10:0] TBL_BASE_S = 11'h3e0;
    localparam logic [14:0] PORT_RST   = 15'h7fff;
    localparam logic [7:0] HL_RST      = 8'h00;

    typedef enum logic [4:0] {
        OP_NONE, OP_SET_HL,
        OP_RD_IND, OP_WR_IND, OP_RD_DIR, OP_WR_DIR, OP_RD_ZP, OP_WR_ZP,
        OP_TBL_OUT, OP_TBL_LO, OP_TBL_HI,
        OP_BIT_SET, OP_BIT_CLR, OP_BIT_TEST,
        OP_CALL, OP_INTR, OP_RET, OP_INTERRUPT_RETURN
    } op_t;

    typedef enum logic [1:0] {PM_NONE, PM_INC, PM_DEC} pmod_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_TAKE} state_t;
endpackage

// file: include/stk_if.sv
// carrier between the main block and the stack location calculator
// assumes both ends run on mclk
`timescale 1ns/1ps
interface stk_if;
    logic [3:0] stack_location_pointer;
    logic       push;
    logic       t1_used;
    logic       t2_used;
    logic [3:0] loc;
    logic [7:0] base;
    logic       ok;
    modport ctl  (output stack_location_pointer, push, t1_used, t2_used,
                  input  loc, base, ok);
    modport calc (input  stack_location_pointer, push, t1_used, t2_used,
                  output loc, base, ok);
endinterface

// file: logic/stack_calc.sv
// stack location selection and its ram base address
// assumes the pointer value is read from ram by the caller
`timescale 1ns/1ps
module stack_calc
    import addr_pkg::*;
(
    // link to main block
    stk_if.calc s
);
    // R15: push uses pointer, pop pre-increments
    assign s.loc  = s.push ? s.stack_location_pointer : s.stack_location_pointer + 4'h1;
    // R13 R14: four nibbles per location from 40h
    assign s.base = STACK_BASE + {2'b00, s.loc, 2'b00};
    // R19: timer count locations blocked while in use
    assign s.ok   = (s.loc != SPW_BAD)
                  && !(s.loc == LOC_TC1 && s.t1_used)
                  && !(s.loc == LOC_TC2 && s.t2_used);
endmodule

// file: logic/port_bit_dec.sv
// decodes the word pointer into a one-hot port pin select
// assumes pins ordered port 4 bit 0 upward, 15 pins
`timescale 1ns/1ps
module port_bit_dec #(
    parameter int NPINS = 15
) (
    // pointer value
    input  wire logic [3:0]       sel_code,
    // one-hot pin select
    output logic      [NPINS-1:0] sel_hot
);
    // R8: code 0101b lands on port five bit one
    genvar i;
    for (i = 0; i < NPINS; i++) begin : g_bit
        assign sel_hot[i] = (sel_code == 4'(i));
    end
endmodule

// file: logic/cpu_mem_addr.sv
// ram addressing, stack, table output and port bit logic of the cpu
// assumes a synchronous rom answering one cycle after its address
`timescale 1ns/1ps
module cpu_mem_addr
    import addr_pkg::*;
#(
    parameter bit LARGE = 1'b1,
    parameter int NPINS = 15
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // sequencer request
    input  wire logic              req,
    input  wire op_t               op,
    input  wire logic [7:0]        operand,
    input  wire logic [3:0]        wdata,
    input  wire pmod_t             post_mod,
    input  wire logic              carry_flag,
    input  wire logic [10:0]       pc_in,
    input  wire logic [3:0]        flags_in,
    input  wire logic [10:0]       fetch_pc,
    // sequencer answer
    output logic                   busy,
    output logic                   done,
    output logic [3:0]             rdata,
    output logic                   bit_result,
    output logic [10:0]            pc_out,
    output logic [3:0]             flags_out,
    output logic                   flags_load,
    output logic                   stack_fault,
    output logic [7:0]             ram_pointer_pair,
    // program memory
    output logic [10:0]            rom_addr,
    output logic [10:0]            fetch_addr,
    input  wire logic [7:0]        rom_data,
    // timer count access
    input  wire logic              tmr1_used,
    input  wire logic              tmr2_used,
    input  wire logic [1:0]        tmr_upd,
    input  wire logic [11:0]       tmr_val,
    output logic [11:0]            first_timer_count,
    output logic [11:0]            second_timer_count,
    // port pins
    input  wire logic [NPINS-1:0]  pin_in,
    output logic [NPINS-1:0]       port_latch,
    output logic [3:0]             upper_output_port,
    output logic [3:0]             lower_output_port
);
    logic [3:0]       ram [RAM_DEPTH];
    state_t           state_reg;
    op_t              cur_op_reg;
    logic [3:0]       h_reg, l_reg;
    logic [10:0]      rom_addr_reg;
    logic [NPINS-1:0] latch_reg;
    logic             done_reg, bit_reg, fl_reg, fault_reg;
    logic [3:0]       rdata_reg, flags_reg;
    logic [10:0]      pc_reg;
    logic [NPINS-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
    logic             spw_known_reg;

    // ram index folding: small variant drops address bit 6
    function automatic logic [6:0] fold(input logic [7:0] a);
        return LARGE ? a[6:0] : {1'b0, a[5:0]};
    endfunction

    // R10: direct; R11: zero page; R6: pointer pair
    wire is_dir = (op == OP_RD_DIR) || (op == OP_WR_DIR);
    wire is_zp  = (op == OP_RD_ZP)  || (op == OP_WR_ZP);
    wire is_ind = (op == OP_RD_IND) || (op == OP_WR_IND);
    wire is_wr  = (op == OP_WR_IND) || (op == OP_WR_DIR)
               || (op == OP_WR_ZP);
    wire is_rd  = (op == OP_RD_IND) || (op == OP_RD_DIR)
               || (op == OP_RD_ZP);
    wire [7:0] ea = is_dir ? operand
                  : is_zp  ? {4'h0, operand[3:0]}
                  : {h_reg, l_reg};
    // R9: seven bit nibble address; R24: small fold overlaps
    wire [6:0] ram_idx = fold(ea);
    wire [3:0] ram_q   = ram[ram_idx];

    // R16: pointer nibble; R20 R21: counter nibbles
    wire [6:0]  spw_idx = fold(SPW_ADDR);
    wire [3:0]  stack_location_pointer     = ram[spw_idx];
    wire [6:0]  dc_idx0 = fold(DC_ADDR);
    wire [6:0]  dc_idx1 = fold(DC_ADDR + 8'h1);
    wire [6:0]  dc_idx2 = fold(DC_ADDR + 8'h2);
    wire [11:0] dc = {ram[dc_idx2], ram[dc_idx1], ram[dc_idx0]};
    wire [11:0] dc_inc = dc + 12'h1;

    // R22: timer counts read from their nibbles
    wire [6:0] t1_idx = fold(TC1_ADDR);
    wire [6:0] t2_idx = fold(TC2_ADDR);
    assign first_timer_count  = {ram[fold(TC1_ADDR + 8'h2)],
                                 ram[fold(TC1_ADDR + 8'h1)],
                                 ram[t1_idx]};
    assign second_timer_count = {ram[fold(TC2_ADDR + 8'h2)],
                                 ram[fold(TC2_ADDR + 8'h1)],
                                 ram[t2_idx]};

    // stack location selection
    stk_if sif ();
    wire is_push = (op == OP_CALL) || (op == OP_INTR);
    wire is_pop  = (op == OP_RET)  || (op == OP_INTERRUPT_RETURN);
    assign sif.stack_location_pointer     = stack_location_pointer;
    assign sif.push    = is_push;
    assign sif.t1_used = tmr1_used;
    assign sif.t2_used = tmr2_used;
    stack_calc u_stack (
        .s (sif.calc)
    );
    wire [6:0] sk0 = fold(sif.base);
    wire [6:0] sk1 = fold(sif.base + 8'h1);
    wire [6:0] sk2 = fold(sif.base + 8'h2);
    wire [6:0] sk3 = fold(sif.base + 8'h3);
    // R26: nibbles pc low, pc mid, pc top, flags
    wire [10:0] pop_pc    = {ram[sk2][2:0], ram[sk1], ram[sk0]};
    wire [3:0]  pop_flags = ram[sk3];

    // port bit select from the word pointer
    logic [NPINS-1:0] bit_hot;
    port_bit_dec #(.NPINS(NPINS)) u_bits (
        .sel_code (l_reg),
        .sel_hot  (bit_hot)
    );

    // R2 R3: carry joins ram nibble as table index
    wire [10:0] tbl_base = LARGE ? TBL_BASE_L : TBL_BASE_S;
    wire [10:0] tbl_addr = tbl_base | {6'h00, carry_flag, ram_q};
    // R25: small variant ignores counter upper bits
    wire [10:0] dc_rom   = LARGE ? dc[10:0] : {1'b0, dc[9:0]};
    // R4 R5: program fetch mirrored on small variant
    assign fetch_addr = LARGE ? fetch_pc : {1'b0, fetch_pc[9:0]};

    // write enables for the ram
    wire take    = (state_reg == ST_IDLE) && req;
    wire is_tbl  = (op == OP_TBL_OUT) || (op == OP_TBL_LO)
                || (op == OP_TBL_HI);
    // R18: a write of 15 to the pointer nibble is dropped
    wire wr_en   = take && is_wr
                && !(ram_idx == spw_idx && wdata == SPW_BAD);
    wire push_en = take && is_push && sif.ok;
    wire pop_en  = take && is_pop && sif.ok;
    wire push_sat = stack_location_pointer == 4'h0;
    wire dc_en   = (state_reg == ST_TAKE) && (cur_op_reg == OP_TBL_HI);
    // R7: only the word pointer moves after a transfer
    wire [3:0] l_next = (post_mod == PM_INC) ? l_reg + 4'h1
                      : (post_mod == PM_DEC) ? l_reg - 4'h1
                      : l_reg;

    // ram storage, no reset: contents start unknown
    always_ff @(posedge mclk) begin
        // R22 R23: three nibbles per timer, 77h 7bh spared
        if (tmr_upd[0]) begin
            ram[t1_idx]                 <= tmr_val[3:0];
            ram[fold(TC1_ADDR + 8'h1)]  <= tmr_val[7:4];
            ram[fold(TC1_ADDR + 8'h2)]  <= tmr_val[11:8];
        end
        if (tmr_upd[1]) begin
            ram[t2_idx]                 <= tmr_val[3:0];
            ram[fold(TC2_ADDR + 8'h1)]  <= tmr_val[7:4];
            ram[fold(TC2_ADDR + 8'h2)]  <= tmr_val[11:8];
        end
        // R12: call saves pc, interrupt also saves flags
        if (push_en) begin
            ram[sk0] <= pc_in[3:0];
            ram[sk1] <= pc_in[7:4];
            ram[sk2] <= {1'b0, pc_in[10:8]};
            if (op == OP_INTR) begin
                ram[sk3] <= flags_in;
            end
        end
        // counter post-increment after high nibble load
        if (dc_en) begin
            ram[dc_idx0] <= dc_inc[3:0];
            ram[dc_idx1] <= dc_inc[7:4];
            ram[dc_idx2] <= dc_inc[11:8];
        end
        if (wr_en) begin
            ram[ram_idx] <= wdata;
        end
        // R15: decrement after push, increment before pop
        if (push_en && !push_sat) begin
            ram[spw_idx] <= stack_location_pointer - 4'h1;
        end else if (pop_en) begin
            ram[spw_idx] <= sif.loc;
        end
    end

    // R8: three flop pin sampling, accepted once stages agree
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            pin_reg <= '0;
        end else begin
            s1_reg  <= pin_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));
        end
    end

    // sequencer control and register updates
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg    <= ST_IDLE;
            cur_op_reg   <= OP_NONE;
            {h_reg, l_reg} <= HL_RST;
            rom_addr_reg <= '0;
            latch_reg    <= PORT_RST;
            done_reg     <= 1'b0;
            bit_reg      <= 1'b0;
            fl_reg       <= 1'b0;
            fault_reg    <= 1'b0;
            rdata_reg    <= '0;
            flags_reg    <= '0;
            pc_reg       <= '0;
        end else begin
            done_reg <= 1'b0;
            fl_reg   <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (req) begin
                        cur_op_reg <= op;
                        if (is_tbl) begin
                            state_reg    <= ST_WAIT;
                            rom_addr_reg <= (op == OP_TBL_OUT)
                                          ? tbl_addr : dc_rom;
                        end else begin
                            done_reg <= 1'b1;
                        end
                        if (op == OP_SET_HL) begin
                            {h_reg, l_reg} <= operand;
                        end
                        if (is_rd) begin
                            rdata_reg <= ram_q;
                        end
                        if (is_ind) begin
                            l_reg <= l_next;
                        end
                        // R8: word pointer picks the pin
                        if (op == OP_BIT_SET) begin
                            latch_reg <= latch_reg | bit_hot;
                        end
                        if (op == OP_BIT_CLR) begin
                            latch_reg <= latch_reg & ~bit_hot;
                        end
                        if (op == OP_BIT_TEST) begin
                            bit_reg <= |(pin_reg & bit_hot);
                        end
                        // R12: return restores pc, flags on interrupt_return
                        if (pop_en) begin
                            pc_reg    <= pop_pc;
                            flags_reg <= pop_flags;
                            fl_reg    <= (op == OP_INTERRUPT_RETURN);
                        end
                        // R18 R19: refused stack moves are flagged
                        if (is_push || is_pop) begin
                            fault_reg <= !sif.ok
                                      || (is_push && push_sat);
                        end
                    end
                end
                ST_WAIT: begin
                    state_reg <= ST_TAKE;
                end
                ST_TAKE: begin
                    state_reg <= ST_IDLE;
                    done_reg  <= 1'b1;
                    // R1: high nibble up, low nibble down
                    if (cur_op_reg == OP_TBL_OUT) begin
                        latch_reg[11:8] <= rom_data[7:4];
                        latch_reg[7:4]  <= rom_data[3:0];
                    end
                    if (cur_op_reg == OP_TBL_LO) begin
                        rdata_reg <= rom_data[3:0];
                    end
                    if (cur_op_reg == OP_TBL_HI) begin
                        rdata_reg <= rom_data[7:4];
                    end
                end
            endcase
        end
    end

    // helper: pointer has been written by a software ram write; stack moves do not set it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            spw_known_reg <= 1'b0;
        end else if (wr_en && ram_idx == spw_idx) begin
            spw_known_reg <= 1'b1;
        end
    end

    // outputs
    assign busy              = state_reg != ST_IDLE;
    assign done              = done_reg;
    assign rdata             = rdata_reg;
    assign bit_result        = bit_reg;
    assign pc_out            = pc_reg;
    assign flags_out         = flags_reg;
    assign flags_load        = fl_reg;
    assign stack_fault       = fault_reg;
    assign ram_pointer_pair  = {h_reg, l_reg};
    assign rom_addr          = rom_addr_reg;
    assign port_latch        = latch_reg;
    assign upper_output_port = latch_reg[11:8];
    assign lower_output_port = latch_reg[7:4];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_tbl_req;
        take && is_tbl;
    endsequence
    sequence s_tbl_run;
        busy ##1 busy ##1 (done && !busy);
    endsequence

    a_tbl_timing: assert property (s_tbl_req |=> s_tbl_run) // R1
        else $error("table op did not finish in three cycles");
    a_tbl_nibbles: assert property ( // R1
        take && op == OP_TBL_OUT |=> ##2
        upper_output_port == $past(rom_data[7:4])
        && lower_output_port == $past(rom_data[3:0]))
        else $error("table byte not split onto ports");
    a_tbl_index: assert property ( // R3
        take && op == OP_TBL_OUT |=>
        rom_addr == (tbl_base | {6'h00, $past(carry_flag),
                                 $past(ram_q)}))
        else $error("table address wrong");
    a_rom_mirror: assert property ( // R5
        !LARGE |-> !rom_addr[10] && !fetch_addr[10])
        else $error("small variant rom top bit set");
    a_l_postmod: assert property ( // R7
        take && is_ind && post_mod == PM_INC |=>
        l_reg == $past(l_reg) + 4'h1 && h_reg == $past(h_reg))
        else $error("word pointer post increment wrong");
    a_bit_set: assert property ( // R8
        take && op == OP_BIT_SET && l_reg < 4'(NPINS) |=>
        port_latch[$past(l_reg)])
        else $error("pointer bit set missed");
    a_spw_push: assert property ( // R15
        take && push_en && !push_sat && !tmr_upd[0] |=>
        stack_location_pointer == $past(stack_location_pointer) - 4'h1)
        else $error("pointer not decremented after push");
    a_spw_range: assert property ( // R18
        spw_known_reg && !push_en && !pop_en |=> stack_location_pointer != SPW_BAD)
        else $error("stack pointer holds 15");
    a_ret_flags: assert property ( // R12
        take && op == OP_RET |=> !flags_load ##1 !flags_load)
        else $error("plain return restored flags");
endmodule

// file: bench/rom_model.sv
// synchronous program memory model answering the table operations
// assumes rom_addr is registered by the block on the same mclk
`timescale 1ns/1ps
module rom_model (
    // clock
    input  wire logic        mclk,
    // address in, byte out
    input  wire logic [10:0] rom_addr,
    output logic      [7:0]  rom_data
);
    // eleven bit space, content mixes all address bits
    always_ff @(posedge mclk) begin
        rom_data <= rom_addr[7:0] ^ {rom_addr[10:8], 5'h0b};
    end
endmodule

// file: bench/cpu_mem_addr_tb.sv
// self-checking bench for the cpu addressing and stack logic
// assumes the large variant and the synchronous rom model beside it
`timescale 1ns/1ps
module cpu_mem_addr_tb;
    import addr_pkg::*;
    // stimulus
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        req = 1'b0;
    op_t         op = OP_NONE;
    logic [7:0]  operand = 8'h00;
    logic [3:0]  wdata = 4'h0;
    pmod_t       post_mod = PM_NONE;
    logic        carry_flag = 1'b0;
    logic [10:0] pc_in = 11'h000;
    logic [3:0]  flags_in = 4'h0;
    logic [10:0] fetch_pc = 11'h000;
    logic        tmr1_used = 1'b0;
    logic        tmr2_used = 1'b0;
    logic [1:0]  tmr_upd = 2'h0;
    logic [11:0] tmr_val = 12'h000;
    logic [14:0] pin_in = 15'h0000;
    // observed
    logic        busy, done, bit_result, flags_load, stack_fault;
    logic [3:0]  rdata, flags_out, upper_output_port, lower_output_port;
    logic [10:0] pc_out, rom_addr, fetch_addr;
    logic [7:0]  ram_pointer_pair, rom_data;
    logic [11:0] first_timer_count, second_timer_count;
    logic [14:0] port_latch;
    int          num_errors = 0;
    int          checked = 0;
    int          cyc = 0;

    cpu_mem_addr #(.LARGE(1'b1), .NPINS(15)) uut (
        .mclk(mclk), .sys_rst(sys_rst), .req(req), .op(op),
        .operand(operand), .wdata(wdata), .post_mod(post_mod),
        .carry_flag(carry_flag), .pc_in(pc_in), .flags_in(flags_in),
        .fetch_pc(fetch_pc), .busy(busy), .done(done), .rdata(rdata),
        .bit_result(bit_result), .pc_out(pc_out), .flags_out(flags_out),
        .flags_load(flags_load), .stack_fault(stack_fault),
        .ram_pointer_pair(ram_pointer_pair), .rom_addr(rom_addr),
        .fetch_addr(fetch_addr), .rom_data(rom_data),
        .tmr1_used(tmr1_used), .tmr2_used(tmr2_used), .tmr_upd(tmr_upd),
        .tmr_val(tmr_val), .first_timer_count(first_timer_count),
        .second_timer_count(second_timer_count), .pin_in(pin_in),
        .port_latch(port_latch), .upper_output_port(upper_output_port),
        .lower_output_port(lower_output_port)
    );
    rom_model rom (.mclk(mclk), .rom_addr(rom_addr), .rom_data(rom_data));

    // 25 mhz clock and cycle ceiling
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            close_out();
        end
    end

    // expected rom content
    function automatic logic [7:0] rom_byte(input logic [10:0] a);
        return a[7:0] ^ {a[10:8], 5'h0b};
    endfunction

    task automatic close_out();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one request, held over the taking edge, then wait for done
    task automatic run(input op_t o, input logic [7:0] opd,
                       input logic [3:0] wd, input pmod_t pm);
        int n;
        @(negedge mclk);
        op = o;
        operand = opd;
        wdata = wd;
        post_mod = pm;
        req = 1'b1;
        @(negedge mclk);
        req = 1'b0;
        chk(busy, o inside {OP_TBL_OUT, OP_TBL_LO, OP_TBL_HI});
        n = 0;
        while (done !== 1'b1 && n < 5) begin
            @(negedge mclk);
            n++;
        end
        chk(done, 1'b1);
    endtask

    task automatic rdd(input logic [7:0] a, input logic [3:0] exp);
        run(OP_RD_DIR, a, 4'h0, PM_NONE);
        chk(rdata, exp);
    endtask

    initial begin
        logic [3:0]  d, w, fl;
        logic [7:0]  b;
        logic [10:0] pc, pc2, a;
        logic [11:0] dcv;
        void'($urandom(75));
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        chk(port_latch, 15'h7fff);
        chk(ram_pointer_pair, 8'h00);
        fetch_pc = 11'($urandom);
        #1 chk(fetch_addr, fetch_pc);
        // port bit clear, set and test through the word pointer
        run(OP_SET_HL, 8'h05, 4'h0, PM_NONE);
        run(OP_BIT_CLR, 8'h00, 4'h0, PM_NONE);
        chk(port_latch, 15'h7fdf);
        run(OP_BIT_SET, 8'h00, 4'h0, PM_NONE);
        chk(port_latch, 15'h7fff);
        for (int i = 0; i < 4; i++) begin
            w = 4'($urandom_range(0, 14));
            pin_in = 15'($urandom);
            repeat (4) @(negedge mclk);
            run(OP_SET_HL, {4'h0, w}, 4'h0, PM_NONE);
            run(OP_BIT_TEST, 8'h00, 4'h0, PM_NONE);
            chk(bit_result, pin_in[w]);
        end
        // indirect access with post modify, word wrap corner first
        for (int i = 0; i < 4; i++) begin
            w = (i == 0) ? 4'hf : 4'($urandom);
            b = {4'($urandom_range(0, 5)), w};
            d = 4'($urandom);
            run(OP_SET_HL, b, 4'h0, PM_NONE);
            run(OP_WR_IND, 8'h00, d, PM_INC);
            chk(ram_pointer_pair, {b[7:4], w + 4'h1});
            rdd(b, d);
            run(OP_RD_IND, 8'h00, 4'h0, PM_DEC);
            chk(ram_pointer_pair, b);
            d = 4'($urandom);
            run(OP_WR_ZP, {4'ha, w}, d, PM_NONE);
            rdd({4'h0, w}, d);
            run(OP_RD_ZP, {4'h5, w}, 4'h0, PM_NONE);
            chk(rdata, d);
        end
        // table counter load, table reads, counter increment
        dcv = {8'($urandom), 4'hf};
        for (int i = 0; i < 3; i++) begin
            run(OP_WR_DIR, DC_ADDR + 8'(i), dcv[4*i +: 4], PM_NONE);
        end
        b = rom_byte(dcv[10:0]);
        run(OP_TBL_LO, 8'h00, 4'h0, PM_NONE);
        chk(rom_addr, dcv[10:0]);
        chk(rdata, b[3:0]);
        run(OP_TBL_HI, 8'h00, 4'h0, PM_NONE);
        chk(rdata, b[7:4]);
        dcv = dcv + 12'h001;
        for (int i = 0; i < 3; i++) begin
            rdd(8'h7c + 8'(i), dcv[4*i +: 4]);
        end
        // conversion table output for both carry values
        for (int c = 0; c < 2; c++) begin
            d = 4'($urandom);
            run(OP_SET_HL, 8'h2f, 4'h0, PM_NONE);
            run(OP_WR_IND, 8'h00, d, PM_NONE);
            carry_flag = c[0];
            run(OP_TBL_OUT, 8'h00, 4'h0, PM_NONE);
            a = 11'h7e0 | {6'h00, c[0], d};
            b = rom_byte(a);
            chk(rom_addr, a);
            chk({upper_output_port, lower_output_port}, b);
        end
        // call and interrupt pushes, returns in reverse order
        run(OP_WR_DIR, SPW_ADDR, 4'hc, PM_NONE);
        pc = 11'($urandom);
        pc_in = pc;
        run(OP_CALL, 8'h00, 4'h0, PM_NONE);
        rdd(SPW_ADDR, 4'hb);
        rdd(8'h70, pc[3:0]);
        rdd(8'h71, pc[7:4]);
        rdd(8'h72, {1'b0, pc[10:8]});
        pc2 = 11'($urandom);
        fl = 4'($urandom);
        pc_in = pc2;
        flags_in = fl;
        run(OP_INTR, 8'h00, 4'h0, PM_NONE);
        rdd(8'h6f, fl);
        run(OP_INTERRUPT_RETURN, 8'h00, 4'h0, PM_NONE);
        chk(flags_load, 1'b1);
        chk({pc_out, flags_out}, {pc2, fl});
        run(OP_RET, 8'h00, 4'h0, PM_NONE);
        chk(flags_load, 1'b0);
        chk(pc_out, pc);
        rdd(SPW_ADDR, 4'hc);
        run(OP_WR_DIR, SPW_ADDR, 4'h3, PM_NONE);
        run(OP_CALL, 8'h00, 4'h0, PM_NONE);
        rdd(8'h4c, pc2[3:0]);
        run(OP_WR_DIR, SPW_ADDR, SPW_BAD, PM_NONE);
        rdd(SPW_ADDR, 4'h2);
        // timer owned location refuses a push
        run(OP_WR_DIR, SPW_ADDR, LOC_TC1, PM_NONE);
        tmr1_used = 1'b1;
        run(OP_CALL, 8'h00, 4'h0, PM_NONE);
        chk(stack_fault, 1'b1);
        rdd(SPW_ADDR, LOC_TC1);
        tmr1_used = 1'b0;
        run(OP_CALL, 8'h00, 4'h0, PM_NONE);
        chk(stack_fault, 1'b0);
        // timer counts in ram, spare nibbles untouched
        d = 4'($urandom);
        run(OP_WR_DIR, 8'h77, d, PM_NONE);
        run(OP_WR_DIR, 8'h7b, ~d, PM_NONE);
        tmr_val = 12'($urandom);
        tmr1_used = 1'b1;
        tmr2_used = 1'b1;
        tmr_upd = 2'h3;
        @(negedge mclk);
        tmr_upd = 2'h0;
        chk(first_timer_count, tmr_val);
        chk(second_timer_count, tmr_val);
        rdd(TC1_ADDR, tmr_val[3:0]);
        rdd(8'h77, d);
        rdd(8'h7b, ~d);
        close_out();
    end
endmodule
